// ---- sfpf_pkg.sv ----
package sfpf_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SCSR = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_LEG = 8'h0C;
  localparam logic [7:0] ADDR_VEC = 8'h20;
  localparam logic [7:0] ADDR_IMG = 8'h40;
  localparam int unsigned NVEC = 8;
  localparam int unsigned IMG_WORDS = 10;
  localparam int unsigned IMG_SCSR = 8;
  localparam int unsigned IMG_LEG = 9;
  localparam int unsigned CTRL_TS = 0;
  localparam int unsigned CTRL_EM = 1;
  localparam int unsigned CTRL_OSXF = 2;
  localparam int unsigned CTRL_NE = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam int unsigned NCOND = 6;
  localparam int unsigned SCSR_FLAG_LSB = 0;
  localparam int unsigned SCSR_MASK_LSB = 7;
  localparam int unsigned SCSR_MASK_MSB = 12;
  localparam logic [31:0] SCSR_RST = 32'h0000_0000;
  localparam logic [31:0] LEG_RST = 32'h0000_0000;
  localparam logic [3:0] CL_LEGACY_FP = 4'h1;
  localparam logic [3:0] CL_PACKED_INT = 4'h2;
  localparam logic [3:0] CL_VEC_FP = 4'h3;
  localparam logic [3:0] CL_VEC_INT = 4'h4;
  localparam logic [3:0] CL_REG_ACCESS = 4'h5;
  localparam logic [3:0] CL_VMOVE = 4'h6;
  localparam logic [3:0] CL_LDCSR = 4'h7;
  localparam logic [3:0] CL_FSAVE = 4'h8;
  localparam logic [3:0] CL_FRSTOR = 4'h9;
  localparam logic [3:0] CL_CLEAR_TASK_SWITCH_INSTR = 4'hA;
  typedef enum logic [4:0] {
    FLT_NONE = 5'b00001,
    FLT_XF = 5'b00010,
    FLT_UD = 5'b00100,
    FLT_NM = 5'b01000,
    FLT_MF = 5'b10000
  } sfpf_fault_t;
endpackage

// ---- sfpf_unit.sv ----
// The Wishbone slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Operation
// - Vector floating-point ops detect invalid, zero-divide, denormal, overflow, underflow, inexact.
// - Packed integer vector operations never raise a numeric fault.
// - Masked conditions write a default result and continue without a fault.
// - Any unmasked condition raises the SIMD floating-point fault.
// - Vector faults ignore the error-report flag and ignore-error pin.
// - With the coprocessor-trap flag set, vector instructions raise invalid opcode.
// - Vector state is the vector registers plus the SIMD control/status register.
// - Full-state save and restore also carry legacy floating-point and integer state.
// - Task-switched flag set raises device-unavailable before any extended-state instruction.
// - Task-switched flag is set by control write or hardware task switch.
// - The clear instruction clears the flag; handlers clear only after saving state.
// - Unmasked condition without the support flag raises invalid opcode instead.
// - Mask bits 7 through 12 of the control/status register, one per condition.
module sfpf_unit (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic instr_valid,
  input wire logic [3:0] instr_class,
  input wire logic [sfpf_pkg::NCOND-1:0] instr_cond,
  input wire logic [2:0] instr_index,
  input wire logic [31:0] instr_wdata,
  input wire logic hw_task_switch,
  input wire logic ignore_fp_error_pin,
  output logic instr_done,
  output logic fault_valid,
  output sfpf_pkg::sfpf_fault_t fault_code,
  output logic default_result_wr
);
  import sfpf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_vector(input logic [3:0] c);
    return (c == CL_VEC_FP) || (c == CL_VEC_INT) || (c == CL_VMOVE) || (c == CL_LDCSR);
  endfunction

  function automatic logic uses_state(input logic [3:0] c);
    return (c != CL_CLEAR_TASK_SWITCH_INSTR) && (c != 4'h0) && (c <= CL_FRSTOR);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic ign_s1_q;
  logic ign_s2_q;
  logic [3:0] ctrl_q;
  logic [31:0] scsr_q;
  logic [31:0] leg_q;
  logic [31:0] vec_q [NVEC];
  logic [31:0] img_q [IMG_WORDS];
  logic ack_q;
  logic [31:0] rdat_q;
  logic done_q;
  logic fvalid_q;
  sfpf_fault_t fcode_q;
  sfpf_fault_t fcode_d;
  logic dflt_q;
  logic dflt_d;
  logic [NCOND-1:0] last_cond_q;
  logic wb_req;
  logic wb_wr;
  logic [NCOND-1:0] masks;
  logic [NCOND-1:0] fp_cond;
  logic [NCOND-1:0] unmasked;
  logic trap_ud;
  logic trap_nm;
  logic exec;

  assign wb_req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
  assign masks = scsr_q[SCSR_MASK_MSB:SCSR_MASK_LSB];
  assign fp_cond = (instr_class == CL_VEC_FP) ? instr_cond : '0;
  assign unmasked = fp_cond & ~masks;
  assign trap_ud = instr_valid && is_vector(instr_class) && ctrl_q[CTRL_EM];
  assign trap_nm = instr_valid && !trap_ud && uses_state(instr_class) && ctrl_q[CTRL_TS];
  assign exec = instr_valid && !trap_ud && !trap_nm;

  ////////////////////////////////////////////////////////////////////////////
  // The pin is asynchronous to the core, so only the second stage is used.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ign_s1_q <= 1'b0;
      ign_s2_q <= 1'b0;
    end else begin
      ign_s1_q <= ignore_fp_error_pin;
      ign_s2_q <= ign_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    fcode_d = FLT_NONE;
    dflt_d = 1'b0;
    if (trap_ud) begin
      fcode_d = FLT_UD;
    end else if (trap_nm) begin
      fcode_d = FLT_NM;
    end else if (exec && instr_class == CL_VEC_FP) begin
      if (|unmasked) begin
        fcode_d = ctrl_q[CTRL_OSXF] ? FLT_XF : FLT_UD;
      end else if (|fp_cond) begin
        dflt_d = 1'b1;
      end
    end else if (exec && instr_class == CL_LEGACY_FP) begin
      // Only the legacy path honours the report flag and the ignore pin.
      if (|instr_cond && ctrl_q[CTRL_NE] && !ign_s2_q) begin
        fcode_d = FLT_MF;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      done_q <= 1'b0;
      fvalid_q <= 1'b0;
      fcode_q <= FLT_NONE;
      dflt_q <= 1'b0;
      last_cond_q <= '0;
    end else begin
      done_q <= instr_valid;
      fvalid_q <= instr_valid && (fcode_d != FLT_NONE);
      dflt_q <= dflt_d;
      if (instr_valid) begin
        fcode_q <= fcode_d;
        last_cond_q <= fp_cond;
      end
    end
  end

  assign instr_done = done_q;
  assign fault_valid = fvalid_q;
  assign fault_code = fcode_q;
  assign default_result_wr = dflt_q;

  ////////////////////////////////////////////////////////////////////////////
  // A hardware task switch wins over both a clear instruction and a control write.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ctrl_q <= CTRL_RST;
    end else begin
      if (wb_wr && wb_adr_i == ADDR_CTRL && wb_sel_i[0]) begin
        ctrl_q <= wb_dat_i[3:0];
      end
      if (exec && instr_class == CL_CLEAR_TASK_SWITCH_INSTR) begin
        ctrl_q[CTRL_TS] <= 1'b0;
      end
      if (hw_task_switch) begin
        ctrl_q[CTRL_TS] <= 1'b1;
      end
    end
  end

  // Sticky condition flags are ORed in last so a same-cycle write cannot drop them.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      scsr_q <= SCSR_RST;
    end else begin
      if (wb_wr && wb_adr_i == ADDR_SCSR) begin
        scsr_q <= merge(scsr_q, wb_dat_i, wb_sel_i);
      end
      if (exec && instr_class == CL_LDCSR) begin
        scsr_q <= instr_wdata;
      end
      if (exec && instr_class == CL_FRSTOR) begin
        scsr_q <= img_q[IMG_SCSR];
      end
      if (exec && |fp_cond) begin
        scsr_q[SCSR_FLAG_LSB +: NCOND] <= scsr_q[SCSR_FLAG_LSB +: NCOND] | fp_cond;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      leg_q <= LEG_RST;
    end else if (exec && instr_class == CL_FRSTOR) begin
      leg_q <= img_q[IMG_LEG];
    end else if (wb_wr && wb_adr_i == ADDR_LEG) begin
      leg_q <= merge(leg_q, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < NVEC; i++) begin
        vec_q[i] <= 32'h0000_0000;
      end
    end else begin
      for (int i = 0; i < NVEC; i++) begin
        if (exec && instr_class == CL_FRSTOR) begin
          vec_q[i] <= img_q[i];
        end else if (exec && instr_class == CL_VMOVE && instr_index == i[2:0]) begin
          vec_q[i] <= instr_wdata;
        end else if (wb_wr && wb_adr_i == ADDR_VEC + 8'(4 * i)) begin
          vec_q[i] <= merge(vec_q[i], wb_dat_i, wb_sel_i);
        end
      end
    end
  end

  // The image is one memory block holding vector, control and legacy state together.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < IMG_WORDS; i++) begin
        img_q[i] <= 32'h0000_0000;
      end
    end else if (exec && instr_class == CL_FSAVE) begin
      for (int i = 0; i < NVEC; i++) begin
        img_q[i] <= vec_q[i];
      end
      img_q[IMG_SCSR] <= scsr_q;
      img_q[IMG_LEG] <= leg_q;
    end else begin
      for (int i = 0; i < IMG_WORDS; i++) begin
        if (wb_wr && wb_adr_i == ADDR_IMG + 8'(4 * i)) begin
          img_q[i] <= merge(img_q[i], wb_dat_i, wb_sel_i);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Every access is acked one cycle after the strobe; writes land at the ack edge, unmapped reads return zero.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= wb_req;
      rdat_q <= 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
        if (wb_adr_i == ADDR_CTRL) begin
          rdat_q <= {28'h0000000, ctrl_q};
        end else if (wb_adr_i == ADDR_SCSR) begin
          rdat_q <= scsr_q;
        end else if (wb_adr_i == ADDR_STAT) begin
          rdat_q <= {21'h0, last_cond_q, fcode_q};
        end else if (wb_adr_i == ADDR_LEG) begin
          rdat_q <= leg_q;
        end
        for (int i = 0; i < NVEC; i++) begin
          if (wb_adr_i == ADDR_VEC + 8'(4 * i)) begin
            rdat_q <= vec_q[i];
          end
        end
        for (int i = 0; i < IMG_WORDS; i++) begin
          if (wb_adr_i == ADDR_IMG + 8'(4 * i)) begin
            rdat_q <= img_q[i];
          end
        end
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  em_trap_a: assert property (
    instr_valid && is_vector(instr_class) && ctrl_q[CTRL_EM] |=> fault_valid && fault_code == FLT_UD)
    else $error("Vector instruction with trap flag did not raise invalid opcode.");

  ts_trap_a: assert property (
    instr_valid && uses_state(instr_class) && ctrl_q[CTRL_TS] && !(is_vector(instr_class) && ctrl_q[CTRL_EM])
    |=> fault_code == FLT_NM && !default_result_wr)
    else $error("Task-switched flag did not raise device unavailable.");

  int_nofault_a: assert property (
    instr_valid && instr_class == CL_VEC_INT && !ctrl_q[CTRL_TS] && !ctrl_q[CTRL_EM] |=> !fault_valid)
    else $error("Packed integer operation raised a fault.");

  masked_dflt_a: assert property (
    exec && instr_class == CL_VEC_FP && instr_cond != '0 && (instr_cond & ~scsr_q[12:7]) == '0
    |=> default_result_wr && !fault_valid)
    else $error("Masked condition did not write a default result.");

  unmasked_xf_a: assert property (
    exec && instr_class == CL_VEC_FP && (instr_cond & ~scsr_q[12:7]) != '0 && ctrl_q[CTRL_OSXF]
    |=> fault_valid && fault_code == FLT_XF ##1 (!fault_valid || $past(instr_valid)))
    else $error("Unmasked condition did not raise the vector fault.");

  nosup_ud_a: assert property (
    exec && instr_class == CL_VEC_FP && (instr_cond & ~scsr_q[12:7]) != '0 && !ctrl_q[CTRL_OSXF]
    |=> fault_code == FLT_UD)
    else $error("Unmasked condition without support did not raise invalid opcode.");

  vec_nomf_a: assert property (
    instr_valid && is_vector(instr_class) |=> fault_code != FLT_MF)
    else $error("Vector instruction used the legacy error path.");

  ts_set_a: assert property (
    hw_task_switch |=> ctrl_q[CTRL_TS])
    else $error("Hardware task switch did not set the task-switched flag.");

  clear_task_switch_instr_a: assert property (
    exec && instr_class == CL_CLEAR_TASK_SWITCH_INSTR && !hw_task_switch && !(wb_wr && wb_adr_i == ADDR_CTRL) |=> !ctrl_q[CTRL_TS])
    else $error("Clear instruction did not clear the task-switched flag.");

  sticky_flag_a: assert property (
    exec && instr_class == CL_VEC_FP |=> (scsr_q[5:0] & $past(instr_cond)) == $past(instr_cond))
    else $error("Detected condition was not recorded.");

  save_img_a: assert property (
    exec && instr_class == CL_FSAVE |=> img_q[IMG_LEG] == $past(leg_q) && img_q[IMG_SCSR] == $past(scsr_q))
    else $error("Full save did not capture legacy and control state.");

  wb_ack_a: assert property (wb_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Bus access not acked for exactly one cycle.");

  xf_seen_c: cover property (fault_valid && fault_code == FLT_XF);
  nm_seen_c: cover property (fault_valid && fault_code == FLT_NM);
  dflt_seen_c: cover property (default_result_wr);
  restore_c: cover property (exec && instr_class == CL_FRSTOR);
endmodule

// ---- test_simd_fp_fault_and_lazy_state_check.sv ----
`timescale 1ns/1ps
module test_simd_fp_fault_and_lazy_state_check;
  import sfpf_pkg::*;
  logic core_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, instr_class;
  logic [31:0] wb_dat_i, wb_dat_o, instr_wdata, scsr, leg;
  logic instr_valid, hw_task_switch, ignore_fp_error_pin, instr_done, fault_valid, default_result_wr;
  logic [NCOND-1:0] instr_cond;
  logic [2:0] instr_index;
  sfpf_fault_t fault_code;
  int fail_count, n_tests, k;
  logic [31:0] rd_q[$];
  logic [6:0] in_q[$];
  logic [31:0] vec[NVEC];
  sfpf_unit sfpf_unit_inst (.core_clk(core_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .instr_valid(instr_valid), .instr_class(instr_class), .instr_cond(instr_cond),
    .instr_index(instr_index), .instr_wdata(instr_wdata), .hw_task_switch(hw_task_switch),
    .ignore_fp_error_pin(ignore_fp_error_pin), .instr_done(instr_done), .fault_valid(fault_valid),
    .fault_code(fault_code), .default_result_wr(default_result_wr));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Read notes carry the expected data; a write leaves no note because dat_o is only meaningful on reads.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    if (!we) rd_q.push_back(dat);
    @(posedge core_clk);
    instr_valid <= 1'b0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= dat;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) fail_count++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic ins(input logic [3:0] cl, input logic [5:0] cd, input logic [2:0] ix, input logic [31:0] wd,
                     input sfpf_fault_t fc, input logic dw);
    in_q.push_back({fc != FLT_NONE, fc, dw});
    @(posedge core_clk);
    instr_valid <= 1'b1;
    instr_class <= cl;
    instr_cond <= cd;
    instr_index <= ix;
    instr_wdata <= wd;
  endtask
  // The pin passes a two-stage synchroniser, so a few edges go by before it counts.
  task automatic pin(input logic v);
    @(posedge core_clk);
    instr_valid <= 1'b0;
    ignore_fp_error_pin <= v;
    repeat (4) @(posedge core_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) check("read data", wb_dat_o, rd_q.pop_front());
    if (instr_done === 1'b1) check("outcome", {25'h0, fault_valid, fault_code, default_result_wr},
                                   {25'h0, in_q.pop_front()});
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    fail_count++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {instr_valid, instr_class, instr_cond, instr_index, instr_wdata, hw_task_switch, ignore_fp_error_pin} = '0;
    void'($urandom(26547));
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    wb(1'b0, ADDR_CTRL, {28'h0, CTRL_RST});
    wb(1'b0, ADDR_SCSR, SCSR_RST);
    wb(1'b0, 8'h80, 32'h0);
    wb(1'b1, ADDR_CTRL, 32'h4);
    for (int i = 0; i < NCOND; i++) ins(CL_VEC_FP, 6'h1 << i, 3'h0, 32'h0, FLT_XF, 1'b0);
    ins(CL_VEC_INT, 6'h3F, 3'h0, 32'h0, FLT_NONE, 1'b0);
    ins(CL_PACKED_INT, 6'h3F, 3'h0, 32'h0, FLT_NONE, 1'b0);
    wb(1'b0, ADDR_SCSR, 32'h3F);
    wb(1'b1, ADDR_CTRL, 32'hC);
    pin(1'b1);
    ins(CL_VEC_FP, 6'(1 + $urandom_range(62)), 3'h0, 32'h0, FLT_XF, 1'b0);
    ins(CL_LEGACY_FP, 6'h01, 3'h0, 32'h0, FLT_NONE, 1'b0);
    pin(1'b0);
    ins(CL_LEGACY_FP, 6'h01, 3'h0, 32'h0, FLT_MF, 1'b0);
    ins(CL_VEC_FP, 6'h04, 3'h0, 32'h0, FLT_XF, 1'b0);
    wb(1'b1, ADDR_CTRL, 32'h0);
    ins(CL_VEC_FP, 6'h02, 3'h0, 32'h0, FLT_UD, 1'b0);
    wb(1'b0, ADDR_STAT, {21'h0, 6'h02, FLT_UD});
    wb(1'b1, ADDR_CTRL, 32'h4);
    wb(1'b1, ADDR_SCSR, 32'h1F80);
    for (int i = 0; i < NCOND; i++) ins(CL_VEC_FP, 6'h1 << i, 3'h0, 32'h0, FLT_NONE, 1'b1);
    ins(CL_VEC_FP, 6'h00, 3'h0, 32'h0, FLT_NONE, 1'b0);
    k = $urandom_range(5);
    wb(1'b1, ADDR_SCSR, 32'h1 << (SCSR_MASK_LSB + k));
    ins(CL_VEC_FP, 6'h1 << k, 3'h0, 32'h0, FLT_NONE, 1'b1);
    ins(CL_VEC_FP, 6'h3F, 3'h0, 32'h0, FLT_XF, 1'b0);
    wb(1'b1, ADDR_CTRL, 32'h6);
    ins(CL_VEC_FP, 6'h00, 3'h0, 32'h0, FLT_UD, 1'b0);
    ins(CL_VEC_INT, 6'h00, 3'h0, 32'h0, FLT_UD, 1'b0);
    ins(CL_VMOVE, 6'h00, 3'h0, 32'h0, FLT_UD, 1'b0);
    wb(1'b1, ADDR_CTRL, 32'h7);
    ins(CL_VEC_FP, 6'h00, 3'h0, 32'h0, FLT_UD, 1'b0);
    wb(1'b1, ADDR_CTRL, 32'h5);
    for (int c = 1; c <= 9; c++) ins(4'(c), 6'h00, 3'h0, 32'h0, FLT_NM, 1'b0);
    ins(CL_CLEAR_TASK_SWITCH_INSTR, 6'h00, 3'h0, 32'h0, FLT_NONE, 1'b0);
    wb(1'b0, ADDR_CTRL, 32'h4);
    @(posedge core_clk);
    hw_task_switch <= 1'b1;
    @(posedge core_clk);
    hw_task_switch <= 1'b0;
    wb(1'b0, ADDR_CTRL, 32'h5);
    ins(CL_CLEAR_TASK_SWITCH_INSTR, 6'h00, 3'h0, 32'h0, FLT_NONE, 1'b0);
    // Random contents make a swapped or stale image word show up as a mismatch.
    for (int i = 0; i < NVEC; i++) begin
      vec[i] = $urandom;
      ins(CL_VMOVE, 6'h00, 3'(i), vec[i], FLT_NONE, 1'b0);
    end
    scsr = $urandom | 32'h1F80;
    ins(CL_LDCSR, 6'h00, 3'h0, scsr, FLT_NONE, 1'b0);
    leg = $urandom;
    wb(1'b1, ADDR_LEG, leg);
    ins(CL_FSAVE, 6'h00, 3'h0, 32'h0, FLT_NONE, 1'b0);
    for (int i = 0; i < NVEC; i++) wb(1'b0, ADDR_IMG + 8'(4 * i), vec[i]);
    wb(1'b0, ADDR_IMG + 8'(4 * IMG_SCSR), scsr);
    wb(1'b0, ADDR_IMG + 8'(4 * IMG_LEG), leg);
    for (int i = 0; i < NVEC; i++) wb(1'b1, ADDR_VEC + 8'(4 * i), ~vec[i]);
    wb(1'b1, ADDR_SCSR, 32'h0);
    wb(1'b1, ADDR_LEG, ~leg);
    ins(CL_FRSTOR, 6'h00, 3'h0, 32'h0, FLT_NONE, 1'b0);
    for (int i = 0; i < NVEC; i++) wb(1'b0, ADDR_VEC + 8'(4 * i), vec[i]);
    wb(1'b0, ADDR_SCSR, scsr);
    wb(1'b0, ADDR_LEG, leg);
    repeat (3) @(posedge core_clk);
    check("pending notes", 32'(rd_q.size() + in_q.size()), 32'h0);
    summarize();
  end
endmodule
